// [design/sdcpi_cmd_if.sv]
// carrier between the command decoder and the pin block
`timescale 1ns/1ps
`default_nettype none
interface sdcpi_cmd_if;
   import sdcpi_pkg::*;
   logic [3:0] strobes_n;
   sdcpi_cmd_t cmd;
   modport dec (input strobes_n, output cmd);
   modport use_side (output strobes_n, input cmd);
endinterface
`default_nettype wire

// [design/sdcpi_decode.sv]
// command decoder for chip select and the three command strobes
`timescale 1ns/1ps
`default_nettype none
module sdcpi_decode (
   sdcpi_cmd_if.dec bus
);
   import sdcpi_pkg::*;

   function automatic sdcpi_cmd_t decode(input logic [3:0] s);
      if (s[3]) begin
         decode = SDCPI_DES;
      end else begin
         decode = sdcpi_cmd_t'(s);
      end
   endfunction

   assign bus.cmd = decode(bus.strobes_n);
endmodule
`default_nettype wire

// [design/sdcpi_pkg.sv]
// shared constants and types for the dram command pin block
package sdcpi_pkg;
   localparam int ADDR_W       = 14;
   localparam int BANK_W       = 3;
   localparam int BANKS        = 8;
   localparam int DATA_W       = 8;
   // pin vector layout after the input synchroniser
   localparam int PIN_CK       = 0;
   localparam int PIN_CKN      = 1;
   localparam int PIN_CKE      = 2;
   localparam int PIN_CMD      = 3;   // 4 bits: cs, ras, cas, we (low active)
   localparam int PIN_BANK     = 7;
   localparam int PIN_ADDR     = 10;
   localparam int PIN_ODT      = 24;
   localparam int PIN_MASK     = 25;
   localparam int PIN_DQS      = 26;
   localparam int PIN_DATA     = 27;
   localparam int PIN_W        = 35;
   // address bits with extra meaning
   localparam int AP_BIT       = 10;
   localparam int BC_BIT       = 12;
   // mode register selection by bank select and field positions
   localparam logic [2:0] MR_ONE_SEL   = 3'h1;
   localparam logic [2:0] MR_TWO_SEL   = 3'h2;
   localparam int MR1_TERMINATION_STROBE_BIT = 11;
   localparam int MR1_RTT_A    = 2;
   localparam int MR1_RTT_B    = 6;
   localparam int MR1_RTT_C    = 9;
   localparam int MR2_RTTWR_LO = 9;
   localparam int MR2_RTTWR_HI = 10;
   localparam logic [13:0] MR_RESET    = 14'h0000;
   // write burst beat counts
   localparam logic [3:0] BEATS_FULL   = 4'h8;
   localparam logic [3:0] BEATS_CHOP   = 4'h4;
   // command codes {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      SDCPI_MRS  = 4'h0,
      SDCPI_REF  = 4'h1,
      SDCPI_PRE  = 4'h2,
      SDCPI_ACT  = 4'h3,
      SDCPI_WR   = 4'h4,
      SDCPI_RD   = 4'h5,
      SDCPI_ZQ   = 4'h6,
      SDCPI_NOP  = 4'h7,
      SDCPI_DES  = 4'h8
   } sdcpi_cmd_t;
   typedef enum logic [1:0] {
      PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
   } sdcpi_pwr_t;
endpackage

// [design/sdcpi_top.sv]
// dram command, clock gate and termination pin behaviour
// Notes on behaviour
// - capture inputs where true rises, complement falls
// - clock gate high enables buffers and drivers
// - gate low enters power-down or self-refresh
// - self-refresh exit seen without the link clock
// - self-refresh disables all but the gate and reset pin
// - chip select high masks the command
// - strobes with chip select decode the command
// - registered termination enable terminates data pins
// - termination ignored when disabled or self-refresh
// - masked write beats are discarded
// - mask sampled on both data strobe edges
// - mode one bit eleven picks mask or strobe
// - bank select steers activate, read, write, precharge
// - bank select picks mode register on set
// - address ten means auto or all precharge
// - address twelve low chops the burst
// - reset pin low clears everything, data lost
`timescale 1ns/1ps
`default_nettype none
module sdcpi_top (
   input  wire  logic                      clock,
   input  wire  logic                      rstn,
   input  wire  logic                      ce,
   input  wire  logic                      dram_reset_n,
   input  wire  logic                      clock_true,
   input  wire  logic                      clock_complement,
   input  wire  logic                      clock_gate,
   input  wire  logic                      chip_select_n,
   input  wire  logic                      row_strobe_n,
   input  wire  logic                      column_strobe_n,
   input  wire  logic                      write_strobe_n,
   input  wire  logic [sdcpi_pkg::BANK_W-1:0] bank_select,
   input  wire  logic [sdcpi_pkg::ADDR_W-1:0] address,
   input  wire  logic                      die_termination_enable,
   input  wire  logic                      write_mask,
   input  wire  logic                      data_strobe,
   input  wire  logic [sdcpi_pkg::DATA_W-1:0] data_in,
   output var   sdcpi_pkg::sdcpi_cmd_t     cmd_code,
   output logic                            cmd_valid,
   output logic [sdcpi_pkg::BANK_W-1:0]    cmd_bank,
   output logic [sdcpi_pkg::ADDR_W-1:0]    cmd_addr,
   output logic                            auto_precharge,
   output logic                            burst_chop,
   output var   sdcpi_pkg::sdcpi_pwr_t     power_state,
   output logic                            input_buffers_on,
   output logic                            output_drivers_on,
   output logic [sdcpi_pkg::BANKS-1:0]     bank_open,
   output logic [sdcpi_pkg::ADDR_W-1:0]    mode_reg_one,
   output logic [sdcpi_pkg::ADDR_W-1:0]    mode_reg_two,
   output logic                            termination_active,
   output logic                            termination_strobe,
   output logic                            beat_valid,
   output logic                            beat_masked,
   output logic [sdcpi_pkg::DATA_W-1:0]    beat_data
);
   import sdcpi_pkg::*;

   // reset: pin or system reset asserts at once, release is synchronous
   logic rst_meta;
   logic rst_ok;
   wire  rst_in_n = rstn & dram_reset_n;

   always_ff @(posedge clock or negedge rst_in_n) begin
      if (!rst_in_n) begin
         rst_meta <= 1'b0;
         rst_ok   <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_ok   <= rst_meta;
      end
   end

   // every pin but the reset pin crosses two flops before use
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_s;
   logic             ck_prev;
   logic             dqs_prev;
   wire  [PIN_W-1:0] pin_raw = {data_in, data_strobe, write_mask,
                                die_termination_enable, address,
                                bank_select, chip_select_n, row_strobe_n,
                                column_strobe_n, write_strobe_n,
                                clock_gate, clock_complement, clock_true};

   always_ff @(posedge clock or negedge rst_ok) begin
      if (!rst_ok) begin
         pin_meta <= '0;
         pin_s    <= '0;
         ck_prev  <= 1'b0;
         dqs_prev <= 1'b0;
      end else if (ce) begin
         pin_meta <= pin_raw;
         pin_s    <= pin_meta;
         ck_prev  <= pin_s[PIN_CK];
         dqs_prev <= pin_s[PIN_DQS];
      end
   end

   wire              s_cke  = pin_s[PIN_CKE];
   wire [BANK_W-1:0] s_bank = pin_s[PIN_BANK +: BANK_W];
   wire [ADDR_W-1:0] s_addr = pin_s[PIN_ADDR +: ADDR_W];
   wire [DATA_W-1:0] s_data = pin_s[PIN_DATA +: DATA_W];
   // crossing: true clock rising while complement is low
   wire ck_edge = pin_s[PIN_CK] & ~ck_prev & ~pin_s[PIN_CKN];
   wire dqs_edge = pin_s[PIN_DQS] ^ dqs_prev;

   // command decode in its own module
   sdcpi_cmd_if cbus ();
   assign cbus.strobes_n = pin_s[PIN_CMD +: 4];
   sdcpi_decode u_decode (
      .bus (cbus.dec)
   );
   wire sdcpi_cmd_t cmd_now = cbus.cmd;

   // power state
   sdcpi_pwr_t state;
   sdcpi_pwr_t next_state;
   wire        any_open = |bank_open;
   wire        pwr_on   = (state == PWR_ON);

   always_comb begin
      next_state = state;
      case (state)
         PWR_ON: begin
            if (ck_edge && !s_cke) begin
               if (cmd_now == SDCPI_REF) begin
                  next_state = PWR_SELF_REF;
               end else if (any_open) begin
                  next_state = PWR_ACT_PD;
               end else begin
                  next_state = PWR_PRE_PD;
               end
            end
         end
         PWR_PRE_PD, PWR_ACT_PD: begin
            if (ck_edge && s_cke) begin
               next_state = PWR_ON;
            end
         end
         PWR_SELF_REF: begin
            // no link clock edge needed, the clock may be stopped
            if (s_cke) begin
               next_state = PWR_ON;
            end
         end
         default: next_state = PWR_ON;
      endcase
   end

   // commands are only taken in the powered state with the gate high
   wire take    = ck_edge & pwr_on & s_cke;
   wire cmd_act = take & (cmd_now != SDCPI_DES)
                       & (cmd_now != SDCPI_NOP);
   wire is_rw   = (cmd_now == SDCPI_RD) | (cmd_now == SDCPI_WR);
   wire ap_set  = s_addr[AP_BIT];
   wire bc_full = s_addr[BC_BIT];

   always_ff @(posedge clock or negedge rst_ok) begin
      if (!rst_ok) begin
         state          <= PWR_ON;
         cmd_valid      <= 1'b0;
         cmd_code       <= SDCPI_NOP;
         cmd_bank       <= '0;
         cmd_addr       <= '0;
         auto_precharge <= 1'b0;
         burst_chop     <= 1'b0;
      end else if (ce) begin
         state     <= next_state;
         cmd_valid <= cmd_act;
         if (cmd_act) begin
            cmd_code       <= cmd_now;
            cmd_bank       <= s_bank;
            cmd_addr       <= s_addr;
            auto_precharge <= is_rw & ap_set;
            burst_chop     <= is_rw & ~bc_full;
         end
      end
   end

   // buffers and drivers follow the power state
   always_ff @(posedge clock or negedge rst_ok) begin
      if (!rst_ok) begin
         power_state       <= PWR_ON;
         input_buffers_on  <= 1'b0;
         output_drivers_on <= 1'b0;
      end else if (ce) begin
         power_state       <= next_state;
         input_buffers_on  <= (next_state == PWR_ON);
         output_drivers_on <= (next_state == PWR_ON);
      end
   end

   // eight banks, each with its own row
   logic [ADDR_W-1:0] open_row [BANKS];
   logic [BANKS-1:0]  next_open;
   wire  [BANKS-1:0]  bank_bit = BANKS'(1) << s_bank;

   always_comb begin
      next_open = bank_open;
      if (cmd_act) begin
         case (cmd_now)
            SDCPI_ACT: next_open = bank_open | bank_bit;
            SDCPI_PRE: next_open = ap_set ? '0
                                          : bank_open & ~bank_bit;
            SDCPI_RD, SDCPI_WR: begin
               if (ap_set) begin
                  next_open = bank_open & ~bank_bit;
               end
            end
            default: next_open = bank_open;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_ok) begin
      if (!rst_ok) begin
         bank_open <= '0;
         for (int i = 0; i < BANKS; i++) begin
            open_row[i] <= '0;
         end
      end else if (ce) begin
         bank_open <= next_open;
         if (cmd_act && cmd_now == SDCPI_ACT) begin
            open_row[s_bank] <= s_addr;
         end
      end
   end

   // mode registers: bank select names the register
   wire mrs_hit = cmd_act & (cmd_now == SDCPI_MRS);

   always_ff @(posedge clock or negedge rst_ok) begin
      if (!rst_ok) begin
         mode_reg_one <= MR_RESET;
         mode_reg_two <= MR_RESET;
      end else if (ce) begin
         if (mrs_hit && s_bank == MR_ONE_SEL) begin
            mode_reg_one <= s_addr;
         end
         if (mrs_hit && s_bank == MR_TWO_SEL) begin
            mode_reg_two <= s_addr;
         end
      end
   end

   // termination
   wire termination_strobe_on = mode_reg_one[MR1_TERMINATION_STROBE_BIT];
   wire rtt_on  = mode_reg_one[MR1_RTT_A] | mode_reg_one[MR1_RTT_B]
                | mode_reg_one[MR1_RTT_C] | mode_reg_two[MR2_RTTWR_LO]
                | mode_reg_two[MR2_RTTWR_HI];
   wire sr_now  = (state == PWR_SELF_REF);

   always_ff @(posedge clock or negedge rst_ok) begin
      if (!rst_ok) begin
         termination_active <= 1'b0;
         termination_strobe <= 1'b0;
      end else if (ce) begin
         if (sr_now || !rtt_on) begin
            termination_active <= 1'b0;
            termination_strobe <= 1'b0;
         end else if (ck_edge) begin
            termination_active <= pin_s[PIN_ODT];
            termination_strobe <= pin_s[PIN_ODT] & termination_strobe_on;
         end
      end
   end

   // write beats: one per data strobe edge after a write command
   logic [3:0] beats_left;
   wire        wr_go    = cmd_act & (cmd_now == SDCPI_WR);
   wire        beat_now = dqs_edge & (beats_left != 4'h0) & pwr_on;
   // the shared pin only masks while it is not the termination strobe
   wire        mask_now = pin_s[PIN_MASK] & ~termination_strobe_on;

   always_ff @(posedge clock or negedge rst_ok) begin
      if (!rst_ok) begin
         beats_left  <= 4'h0;
         beat_valid  <= 1'b0;
         beat_masked <= 1'b0;
         beat_data   <= '0;
      end else if (ce) begin
         beat_valid  <= beat_now & ~mask_now;
         beat_masked <= beat_now & mask_now;
         if (wr_go) begin
            beats_left <= bc_full ? BEATS_FULL : BEATS_CHOP;
         end else if (beat_now) begin
            beats_left <= beats_left - 4'h1;
         end
         if (beat_now && !mask_now) begin
            beat_data <= s_data;
         end
      end
   end
endmodule
`default_nettype wire

// [test/sdcpi_ctrl_model.sv]
// memory controller model driving the dram command and data pins
`timescale 1ns/1ps
`default_nettype none
module sdcpi_ctrl_model (
   input  wire logic        clock,
   output logic             clock_true = 1'b0,
   output logic             clock_complement = 1'b1,
   output logic             clock_gate = 1'b1,
   output logic [3:0]       strobes_n = 4'h7,
   output logic [2:0]       bank_select = 3'h0,
   output logic [13:0]      address = 14'h0000,
   output logic             die_termination_enable = 1'b0,
   output logic             write_mask = 1'b0,
   output logic             data_strobe = 1'b0,
   output logic [7:0]       data_in = 8'h00
);
   // link clock idles between frames; pins settle half a period first
   task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                      input logic [13:0] a, input logic g, o);
      @(posedge clock);
      #1;
      strobes_n = c;
      bank_select = b;
      address = a;
      clock_gate = g;
      die_termination_enable = o;
      #62.5 clock_true = 1'b1;
      clock_complement = 1'b0;
      #62.5 clock_true = 1'b0;
      clock_complement = 1'b1;
   endtask
   // each beat toggles the strobe, so both edges carry data
   task automatic beat(input logic m, input logic [7:0] d);
      @(posedge clock);
      #1;
      write_mask = m;
      data_in = d;
      data_strobe = ~data_strobe;
      repeat (3) @(posedge clock);
   endtask
   task automatic gate(input logic g);
      @(posedge clock);
      #1 clock_gate = g;
   endtask
endmodule
`default_nettype wire

// [test/sdcpi_sva.sv]
// concurrent checks on the dram command pin block
`timescale 1ns/1ps
`default_nettype none
module sdcpi_sva (
   input wire logic                clock,
   input wire logic                rstn,
   input var  sdcpi_pkg::sdcpi_cmd_t cmd_code,
   input wire logic                cmd_valid,
   input wire logic [2:0]          cmd_bank,
   input wire logic [13:0]         cmd_addr,
   input wire logic                auto_precharge,
   input wire logic                burst_chop,
   input var  sdcpi_pkg::sdcpi_pwr_t power_state,
   input wire logic [7:0]          bank_open,
   input wire logic [13:0]         mode_reg_one,
   input wire logic                termination_active,
   input wire logic                termination_strobe,
   input wire logic                beat_valid,
   input wire logic                beat_masked
);
   import sdcpi_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse held too long");
   a_deselect_quiet: assert property (
      cmd_valid |-> !(cmd_code inside {SDCPI_NOP, SDCPI_DES}))
      else $error("pulse for a masked command");
   // stable inputs keep the check clear of register skew
   a_strobe_mode: assert property (
      $stable(mode_reg_one) && $stable(termination_active) |->
      termination_strobe == (termination_active && mode_reg_one[11]))
      else $error("termination strobe wrong");
   a_rdwr_fields: assert property (
      cmd_valid && cmd_code inside {SDCPI_RD, SDCPI_WR} |->
      auto_precharge == cmd_addr[10] && burst_chop == !cmd_addr[12])
      else $error("precharge or chop flag wrong");
   a_act_opens: assert property (
      cmd_valid && cmd_code == SDCPI_ACT |-> bank_open[cmd_bank])
      else $error("activate left bank closed");
   a_pre_closes: assert property (
      cmd_valid && cmd_code == SDCPI_PRE |-> !bank_open[cmd_bank] &&
      (!cmd_addr[10] || bank_open == 8'h00))
      else $error("precharge left a bank open");
   a_mask_drop: assert property (
      beat_masked |-> !beat_valid && !mode_reg_one[11])
      else $error("masked beat taken");
   a_down_no_cmd: assert property (
      power_state != PWR_ON && $past(power_state) != PWR_ON |-> !cmd_valid)
      else $error("command taken while powered down");
   c_self_ref: cover property (power_state == PWR_SELF_REF);
   c_masked: cover property (beat_masked);
   c_write: cover property (cmd_valid && cmd_code == SDCPI_WR);
endmodule
bind sdcpi_top sdcpi_sva chk (.clock(clock), .rstn(rstn),
   .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_bank(cmd_bank),
   .cmd_addr(cmd_addr), .auto_precharge(auto_precharge),
   .burst_chop(burst_chop), .power_state(power_state),
   .bank_open(bank_open), .mode_reg_one(mode_reg_one),
   .termination_active(termination_active),
   .termination_strobe(termination_strobe), .beat_valid(beat_valid),
   .beat_masked(beat_masked));
`default_nettype wire

// [test/sdcpi_top_bench.sv]
// self-checking bench for the dram command pin block
`timescale 1ns/1ps
`default_nettype none
module sdcpi_top_bench;
   import sdcpi_pkg::*;
   logic        clock = 1'b0, rstn = 1'b0, ce = 1'b1, dram_reset_n = 1'b1;
   logic        clock_true, clock_complement, clock_gate, write_mask;
   logic        die_termination_enable, data_strobe, cmd_valid, beat_valid;
   logic        auto_precharge, burst_chop, beat_masked, output_drivers_on;
   logic        input_buffers_on, termination_active, termination_strobe;
   logic [3:0]  strobes_n;
   logic [2:0]  bank_select, cmd_bank, ebk = 3'h0;
   logic [13:0] address, cmd_addr, mode_reg_one, mode_reg_two, ea = 14'h0;
   logic [7:0]  data_in, beat_data, bank_open, eb = 8'h00, d[6];
   sdcpi_cmd_t  cmd_code, ec = SDCPI_NOP;
   sdcpi_pwr_t  power_state;
   int          n_errors = 0, checks = 0, nv = 0, nm = 0, k;
   int          seed = 91993;
   // hot parts need a refresh every 3.9 us on average
   localparam int REFRESH_NS = 3900;
   sdcpi_cmd_t  cl[6] = '{SDCPI_ACT, SDCPI_RD, SDCPI_PRE, SDCPI_ZQ,
                          SDCPI_NOP, SDCPI_DES};
   sdcpi_ctrl_model u_ctl (.clock(clock), .clock_true(clock_true),
      .clock_complement(clock_complement), .clock_gate(clock_gate),
      .strobes_n(strobes_n), .bank_select(bank_select), .address(address),
      .die_termination_enable(die_termination_enable),
      .write_mask(write_mask), .data_strobe(data_strobe),
      .data_in(data_in));
   sdcpi_top uut (.clock(clock), .rstn(rstn), .ce(ce),
      .dram_reset_n(dram_reset_n), .clock_true(clock_true),
      .clock_complement(clock_complement), .clock_gate(clock_gate),
      .chip_select_n(strobes_n[3]), .row_strobe_n(strobes_n[2]),
      .column_strobe_n(strobes_n[1]), .write_strobe_n(strobes_n[0]),
      .bank_select(bank_select), .address(address),
      .die_termination_enable(die_termination_enable),
      .write_mask(write_mask), .data_strobe(data_strobe),
      .data_in(data_in), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
      .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
      .auto_precharge(auto_precharge), .burst_chop(burst_chop),
      .power_state(power_state), .input_buffers_on(input_buffers_on),
      .output_drivers_on(output_drivers_on), .bank_open(bank_open),
      .mode_reg_one(mode_reg_one), .mode_reg_two(mode_reg_two),
      .termination_active(termination_active),
      .termination_strobe(termination_strobe), .beat_valid(beat_valid),
      .beat_masked(beat_masked), .beat_data(beat_data));
   always #5 clock = ~clock;
   always @(posedge clock) begin
      nv <= nv + int'(beat_valid);
      nm <= nm + int'(beat_masked);
   end
   task automatic check(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [7:0] nb(logic [7:0] o, sdcpi_cmd_t c,
                                     logic [2:0] b, logic [13:0] a);
      if (c == SDCPI_ACT) o[b] = 1'b1;
      if (c == SDCPI_PRE || (c inside {SDCPI_RD, SDCPI_WR} && a[10]))
         o[b] = 1'b0;
      if (c == SDCPI_PRE && a[10]) o = 8'h00;
      return o;
   endfunction
   // codes above zq carry a masked or empty command
   task automatic run(input logic [3:0] c, input logic [2:0] b,
                      input logic [13:0] a, input logic o);
      u_ctl.cmd(c, b, a, 1'b1, o);
      if (c < 4'h7) begin
         ec = sdcpi_cmd_t'(c);
         ebk = b;
         ea = a;
         eb = nb(eb, ec, b, a);
      end
      check("code", cmd_code, ec);
      check("bank", cmd_bank, ebk);
      check("addr", cmd_addr, ea);
      check("open", bank_open, eb);
   endtask
   task automatic pwr(input logic [3:0] c, input logic g, sdcpi_pwr_t s);
      u_ctl.cmd(c, 3'h0, 14'h0, g, 1'b1);
      check("power", power_state, s);
   endtask
   task automatic summarize();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1 rstn = 1'b1;
      repeat (8) @(posedge clock);
      #1;
      check("power", power_state, PWR_ON);
      check("buffers", input_buffers_on, 1'b1);
      for (k = 0; k < 24; k++)
         run(cl[$unsigned($random(seed)) % 6], 3'($random(seed)),
             14'($random(seed)), 1'b0);
      $display("test random commands done");
      run(SDCPI_MRS, 3'h1, 14'h0804, 1'b1);
      run(SDCPI_NOP, 3'h0, 14'h0, 1'b1);
      check("term", termination_active, 1'b1);
      check("tstrobe", termination_strobe, 1'b1);
      run(SDCPI_MRS, 3'h1, 14'h0, 1'b1);
      run(SDCPI_MRS, 3'h2, 14'h0080, 1'b1);
      for (k = 0; k < 2; k++) begin
         run(SDCPI_REF, 3'h0, 14'h0, 1'b1);
         #(REFRESH_NS - 130);
      end
      run(SDCPI_NOP, 3'h0, 14'h0, 1'b1);
      check("term", termination_active, 1'b0);
      check("mr2", mode_reg_two, 14'h0080);
      $display("test termination done");
      run(SDCPI_MRS, 3'h1, 14'h0040, 1'b0);
      run(SDCPI_ACT, 3'h3, 14'h1fff, 1'b0);
      run(SDCPI_WR, 3'h3, 14'h0400, 1'b0);
      check("ap", auto_precharge, 1'b1);
      check("chop", burst_chop, 1'b1);
      for (k = 0; k < 6; k++) begin
         d[k] = 8'($random(seed));
         u_ctl.beat(k == 1 || k == 3, d[k]);
      end
      repeat (4) @(posedge clock);
      #1;
      check("beats", 16'(nv), 16'h2);
      check("masked", 16'(nm), 16'h2);
      check("data", beat_data, d[2]);
      $display("test write beats done");
      run(SDCPI_ACT, 3'h5, 14'h0001, 1'b0);
      pwr(SDCPI_NOP, 1'b0, PWR_ACT_PD);
      check("drivers", output_drivers_on, 1'b0);
      pwr(SDCPI_ACT, 1'b0, PWR_ACT_PD);
      check("code", cmd_code, ec);
      pwr(SDCPI_NOP, 1'b1, PWR_ON);
      run(SDCPI_PRE, 3'h0, 14'h0400, 1'b0);
      pwr(SDCPI_NOP, 1'b0, PWR_PRE_PD);
      pwr(SDCPI_NOP, 1'b1, PWR_ON);
      pwr(SDCPI_REF, 1'b0, PWR_SELF_REF);
      check("term", termination_active, 1'b0);
      check("buffers", input_buffers_on, 1'b0);
      u_ctl.gate(1'b1);
      for (k = 0; k < 20 && power_state !== PWR_ON; k++) @(posedge clock);
      #1;
      check("power", power_state, PWR_ON);
      $display("test power states done");
      run(SDCPI_ACT, 3'h2, 14'h0003, 1'b0);
      @(posedge clock);
      #1 dram_reset_n = 1'b0;
      repeat (3) @(posedge clock);
      #1 dram_reset_n = 1'b1;
      check("open", bank_open, 8'h00);
      check("mr1", mode_reg_one, 14'h0);
      $display("test device reset done");
      summarize();
   end
endmodule
`default_nettype wire
